/* include/kpc_pkg.sv */
// Constants for the keypad host power and reset control block.
package kpc_pkg;
    localparam logic [7:0] KEY_UP_BIT = 8'h01;
    localparam logic [7:0] KEY_CONFIRM_BIT = 8'h02;
    localparam logic [7:0] KEY_ABORT_BIT = 8'h04;
    localparam logic [7:0] KEY_WEST_BIT = 8'h08;
    localparam logic [7:0] KEY_EAST_BIT = 8'h10;
    localparam logic [7:0] KEY_LOWER_BIT = 8'h20;
    localparam logic [7:0] KEY_ALL = 8'h3F;
    localparam logic [7:0] FN_RST_INVERT = 8'h02;
    localparam logic [7:0] FN_PWR_INVERT = 8'h04;
    localparam logic [7:0] FN_BLANK_WHEN_HOST_DOWN = 8'h10;
    localparam logic [7:0] FN_KEYPAD_RESET = 8'h20;
    localparam logic [7:0] FN_KEYPAD_PWR_ON = 8'h40;
    localparam logic [7:0] FN_KEYPAD_PWR_OFF = 8'h80;
    localparam logic [7:0] MASK_RESET_VAL = 8'h3F;
    localparam logic [7:0] FN_RESET_VAL = 8'h00;
    localparam logic [7:0] PULSE_LEN_DEFAULT = 8'h20;
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_DIV = 32;
    localparam int TICK_CYCLES = CLK_HZ / TICK_DIV;
    localparam int HOLD_LONG_TICKS = 4 * TICK_DIV;
    localparam int HOLD_SHORT_TICKS = TICK_DIV / 4;
    localparam int RESET_PULSE_TICKS = 1 * TICK_DIV;
    localparam int EXTEND_TICKS = 5 * TICK_DIV;
endpackage : kpc_pkg

/* src/keypad_host_power_control.sv */
// Keypad host power and reset pulse sequencer with key report masking.
`timescale 1ns/1ps
`default_nettype none
module keypad_host_power_control
    import kpc_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [5:0] i_keys,
    input wire logic i_power_sense,
    input wire logic i_cfg_keys_wr,
    input wire logic [7:0] i_cfg_press_mask,
    input wire logic [7:0] i_cfg_release_mask,
    input wire logic i_cfg_fn_wr,
    input wire logic [7:0] i_cfg_fn,
    input wire logic i_cfg_len_valid,
    input wire logic [7:0] i_cfg_pulse_len,
    input wire logic i_save_boot,
    input wire logic i_poll,
    input wire logic i_cmd_valid,
    output logic o_cmd_accept,
    output logic o_key_event,
    output logic o_key_event_press,
    output logic [7:0] o_key_event_bits,
    output logic o_poll_valid,
    output logic [7:0] o_poll_held,
    output logic [7:0] o_poll_pressed,
    output logic [7:0] o_poll_released,
    output logic [7:0] o_boot_press_mask,
    output logic [7:0] o_boot_release_mask,
    output logic o_pwr_out,
    output logic o_pwr_oe,
    output logic o_rst_out,
    output logic o_rst_oe,
    output logic o_display_blank,
    output logic [1:0] o_message,
    output logic o_reboot
);
    // ------------------------------------------------------------------
    // Input synchronisers and 1/32 s tick
    // ------------------------------------------------------------------
    logic [6:0] sync1_reg, sync2_reg, prev_reg;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
            prev_reg <= 7'h00;
        end else begin
            sync1_reg <= {i_power_sense, i_keys};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    logic [7:0] keys;
    logic [7:0] keys_prev;
    logic sense;
    logic sense_rise;
    assign keys = {2'b00, sync2_reg[5:0]};
    assign keys_prev = {2'b00, prev_reg[5:0]};
    assign sense = sync2_reg[6];
    assign sense_rise = sync2_reg[6] & ~prev_reg[6];

    logic [31:0] tick_cnt_reg;
    logic tick;
    assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    logic [7:0] press_mask_reg, release_mask_reg, fn_reg, len_reg;
    logic busy;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            press_mask_reg <= MASK_RESET_VAL;
            release_mask_reg <= MASK_RESET_VAL;
            fn_reg <= FN_RESET_VAL;
            len_reg <= PULSE_LEN_DEFAULT;
            o_boot_press_mask <= MASK_RESET_VAL;
            o_boot_release_mask <= MASK_RESET_VAL;
        end else if (!busy) begin
            if (i_cfg_keys_wr) begin
                press_mask_reg <= i_cfg_press_mask & KEY_ALL;
                release_mask_reg <= i_cfg_release_mask & KEY_ALL;
            end
            if (i_cfg_fn_wr) begin
                fn_reg <= i_cfg_fn;
                if (i_cfg_len_valid && i_cfg_pulse_len != 8'h00) begin
                    len_reg <= i_cfg_pulse_len;
                end
            end
            if (i_save_boot) begin
                o_boot_press_mask <= press_mask_reg;
                o_boot_release_mask <= release_mask_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Key reports and polling
    // ------------------------------------------------------------------
    logic [7:0] pressed_reg, released_reg, prs, rls;
    assign prs = keys & ~keys_prev;
    assign rls = ~keys & keys_prev;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_key_event <= 1'b0;
            o_key_event_press <= 1'b0;
            o_key_event_bits <= 8'h00;
        end else begin
            o_key_event <= |(prs & press_mask_reg) | |(rls & release_mask_reg);
            o_key_event_press <= |(prs & press_mask_reg);
            o_key_event_bits <= (|(prs & press_mask_reg)) ?
                (prs & press_mask_reg) : (rls & release_mask_reg);
        end
    end

    logic poll_go;
    assign poll_go = i_poll & ~busy;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pressed_reg <= 8'h00;
            released_reg <= 8'h00;
            o_poll_valid <= 1'b0;
            o_poll_held <= 8'h00;
            o_poll_pressed <= 8'h00;
            o_poll_released <= 8'h00;
        end else begin
            o_poll_valid <= poll_go;
            if (poll_go) begin
                // Masks are not applied here; activity is always visible.
                o_poll_held <= keys;
                o_poll_pressed <= pressed_reg | prs;
                o_poll_released <= released_reg | rls;
                pressed_reg <= 8'h00;
                released_reg <= 8'h00;
            end else begin
                pressed_reg <= pressed_reg | prs;
                released_reg <= released_reg | rls;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pulse sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_RST_PULSE, ST_ON_PULSE, ST_OFF_PULSE, ST_OFF_EXTEND,
        ST_REBOOT
    } state_t;
    state_t state_reg;
    logic [7:0] hold_reg, time_reg;
    logic confirm, abort_k;
    assign confirm = |(keys & KEY_CONFIRM_BIT);
    assign abort_k = |(keys & KEY_ABORT_BIT);
    assign busy = (state_reg == ST_RST_PULSE) || (state_reg == ST_REBOOT);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= ST_IDLE;
            hold_reg <= 8'h00;
            time_reg <= 8'h00;
        end else begin
            unique case (state_reg)
            ST_IDLE: begin
                if (!(confirm || abort_k)) begin
                    hold_reg <= 8'h00;
                end else if (tick && hold_reg != 8'hFF) begin
                    hold_reg <= hold_reg + 8'h1;
                end
                time_reg <= 8'h00;
                if (sense && confirm && (fn_reg & FN_KEYPAD_RESET) != 8'h00 &&
                    hold_reg == 8'(HOLD_LONG_TICKS)) begin
                    state_reg <= ST_RST_PULSE;
                end else if (!sense && confirm &&
                    (fn_reg & FN_KEYPAD_PWR_ON) != 8'h00 &&
                    hold_reg == 8'(HOLD_SHORT_TICKS)) begin
                    state_reg <= ST_ON_PULSE;
                end else if (sense && abort_k && !confirm &&
                    (fn_reg & FN_KEYPAD_PWR_OFF) != 8'h00 &&
                    hold_reg == 8'(HOLD_LONG_TICKS)) begin
                    state_reg <= ST_OFF_PULSE;
                end else if (sense_rise &&
                    (fn_reg & FN_BLANK_WHEN_HOST_DOWN) != 8'h00) begin
                    state_reg <= ST_REBOOT;
                end
            end
            ST_RST_PULSE, ST_ON_PULSE, ST_OFF_PULSE, ST_OFF_EXTEND: begin
                hold_reg <= 8'h00;
                if (tick) begin
                    time_reg <= time_reg + 8'h1;
                end
                if (state_reg == ST_RST_PULSE && tick &&
                    time_reg == 8'(RESET_PULSE_TICKS - 1)) begin
                    state_reg <= ST_REBOOT;
                end else if (state_reg == ST_ON_PULSE && tick &&
                    time_reg == len_reg - 8'h1) begin
                    state_reg <= ST_REBOOT;
                end else if (state_reg == ST_OFF_PULSE && tick &&
                    time_reg == len_reg - 8'h1) begin
                    time_reg <= 8'h00;
                    state_reg <= abort_k ? ST_OFF_EXTEND : ST_IDLE;
                end else if (state_reg == ST_OFF_EXTEND && (!abort_k ||
                    (tick && time_reg == 8'(EXTEND_TICKS - 1)))) begin
                    state_reg <= ST_IDLE;
                end
            end
            ST_REBOOT: begin
                state_reg <= ST_IDLE;
            end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pins and status outputs
    // ------------------------------------------------------------------
    logic pwr_act, rst_act;
    assign pwr_act = (state_reg == ST_ON_PULSE) || (state_reg == ST_OFF_PULSE)
        || (state_reg == ST_OFF_EXTEND);
    assign rst_act = (state_reg == ST_RST_PULSE);
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pwr_oe <= 1'b0;
            o_pwr_out <= 1'b0;
            o_rst_oe <= 1'b0;
            o_rst_out <= 1'b0;
            o_display_blank <= 1'b0;
            o_message <= 2'b00;
            o_reboot <= 1'b0;
            o_cmd_accept <= 1'b0;
        end else begin
            // Enables fall with the pulse so the line floats again.
            o_pwr_oe <= pwr_act;
            o_rst_oe <= rst_act;
            o_pwr_out <= (fn_reg & FN_PWR_INVERT) != 8'h00;
            o_rst_out <= (fn_reg & FN_RST_INVERT) != 8'h00;
            o_display_blank <= !sense &&
                (fn_reg & FN_BLANK_WHEN_HOST_DOWN) != 8'h00;
            o_message <= rst_act ? 2'h1 : (state_reg == ST_ON_PULSE) ? 2'h2 :
                pwr_act ? 2'h3 : 2'h0;
            o_reboot <= (state_reg == ST_REBOOT);
            o_cmd_accept <= i_cmd_valid && !busy;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_float_idle: assert property ((state_reg == ST_IDLE) |=> !o_pwr_oe
        && !o_rst_oe) else $error("line driven while idle");
    a_pwr_polarity: assert property (o_pwr_oe |-> o_pwr_out ==
        $past((fn_reg & FN_PWR_INVERT) != 8'h00))
        else $error("pwr level");
    a_rst_release: assert property ($fell(rst_act) |=> !o_rst_oe)
        else $error("reset not released");
    a_busy_ignore: assert property (busy && i_cmd_valid |=> !o_cmd_accept)
        else $error("command taken while busy");
    a_rst_reboot: assert property ($fell(rst_act) |-> state_reg == ST_REBOOT)
        else $error("no reboot after reset");
    a_poll_clear: assert property (poll_go |=> o_poll_valid &&
        pressed_reg == 8'h00 && o_poll_pressed == $past(pressed_reg | prs))
        else $error("poll lost");
    a_mask_gate: assert property (press_mask_reg == 8'h00 &&
        release_mask_reg == 8'h00 |=> !o_key_event)
        else $error("masked event reported");
    a_ext_drop: assert property (state_reg == ST_OFF_EXTEND && !abort_k
        |=> state_reg == ST_IDLE) else $error("extend kept");
    c_rst_pulse: cover property (rst_act ##1 state_reg == ST_REBOOT);
    c_on_pulse: cover property (state_reg == ST_ON_PULSE);
    c_extend: cover property (state_reg == ST_OFF_EXTEND);
endmodule : keypad_host_power_control
`default_nettype wire

/* dv/host_board_model.sv */
// Behavioural model of the host board's power, reset and sense pins.
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
    input wire logic i_pwr_out,
    input wire logic i_pwr_oe,
    input wire logic i_rst_out,
    input wire logic i_rst_oe,
    input wire logic i_host_on,
    output logic o_pwr_line,
    output logic o_rst_line,
    output logic o_power_sense
);
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    // Board inputs have pull-ups, so a released line reads high.
    assign o_pwr_line = i_pwr_oe ? i_pwr_out : 1'b1;
    assign o_rst_line = i_rst_oe ? i_rst_out : 1'b1;
    // Sense pin is pulled up when on and pulled down hard when off.
    assign o_power_sense = i_host_on;
endmodule : host_board_model
`default_nettype wire

/* dv/keypad_host_power_control_test.sv */
// Self-checking testbench for the keypad host power and reset control.
`timescale 1ns/1ps
`default_nettype none
module keypad_host_power_control_test;
    import kpc_pkg::*;
    logic i_clk = 1'b0, i_rst_b = 1'b0, host_on = 1'b1;
    logic [5:0] i_keys = '0;
    logic i_cfg_keys_wr = 0, i_cfg_fn_wr = 0, i_cfg_len_valid = 0;
    logic [7:0] i_cfg_press_mask = '0, i_cfg_release_mask = '0;
    logic [7:0] i_cfg_fn = '0, i_cfg_pulse_len = '0;
    logic i_save_boot = 0, i_poll = 0, i_cmd_valid = 0, i_power_sense;
    logic o_cmd_accept, o_key_event, o_key_event_press, o_poll_valid;
    logic [7:0] o_key_event_bits, o_poll_held, o_poll_pressed;
    logic [7:0] o_poll_released, o_boot_press_mask, o_boot_release_mask;
    logic o_pwr_out, o_pwr_oe, o_rst_out, o_rst_oe, o_display_blank;
    logic o_reboot, pwr_line, rst_line;
    logic [1:0] o_message;
    int n_mismatch = 0;
    int tests_run = 0;

    always #4 i_clk = ~i_clk;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    // A short tick keeps the four second holds to a few hundred cycles.
    keypad_host_power_control #(.TICK_CYC(4)) u_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_keys(i_keys),
        .i_power_sense(i_power_sense), .i_cfg_keys_wr(i_cfg_keys_wr),
        .i_cfg_press_mask(i_cfg_press_mask),
        .i_cfg_release_mask(i_cfg_release_mask),
        .i_cfg_fn_wr(i_cfg_fn_wr), .i_cfg_fn(i_cfg_fn),
        .i_cfg_len_valid(i_cfg_len_valid), .i_cfg_pulse_len(i_cfg_pulse_len),
        .i_save_boot(i_save_boot), .i_poll(i_poll),
        .i_cmd_valid(i_cmd_valid), .o_cmd_accept(o_cmd_accept),
        .o_key_event(o_key_event), .o_key_event_press(o_key_event_press),
        .o_key_event_bits(o_key_event_bits), .o_poll_valid(o_poll_valid),
        .o_poll_held(o_poll_held), .o_poll_pressed(o_poll_pressed),
        .o_poll_released(o_poll_released),
        .o_boot_press_mask(o_boot_press_mask),
        .o_boot_release_mask(o_boot_release_mask),
        .o_pwr_out(o_pwr_out), .o_pwr_oe(o_pwr_oe), .o_rst_out(o_rst_out),
        .o_rst_oe(o_rst_oe), .o_display_blank(o_display_blank),
        .o_message(o_message), .o_reboot(o_reboot));
    host_board_model u_host (
        .i_pwr_out(o_pwr_out), .i_pwr_oe(o_pwr_oe), .i_rst_out(o_rst_out),
        .i_rst_oe(o_rst_oe), .i_host_on(host_on), .o_pwr_line(pwr_line),
        .o_rst_line(rst_line), .o_power_sense(i_power_sense));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time,
                     what, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Waits for 0 pwr_oe, 1 rst_oe, 2 key event, 3 reboot pulse.
    task automatic wait_on(input int sel, input int lim);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && hit !== 1'b1; i++) begin
            step(1);
            case (sel)
                0: hit = o_pwr_oe;
                1: hit = o_rst_oe;
                2: hit = o_key_event;
                default: hit = o_reboot;
            endcase
        end
        if (hit !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH at %0t: wait %0d ran out", $time, sel);
            give_verdict();
        end
    endtask : wait_on

    task automatic set_fn(input logic [7:0] fn, input logic [7:0] len);
        i_cfg_fn = fn;
        i_cfg_pulse_len = len;
        i_cfg_len_valid = (len != 8'h00);
        i_cfg_fn_wr = 1'b1;
        step(1);
        i_cfg_fn_wr = 1'b0;
    endtask : set_fn

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reports();
        check({o_pwr_oe, o_rst_oe}, 8'h00, "lines float");
        check(o_boot_press_mask, 8'h3F, "boot press");
        i_keys = 6'h01;
        wait_on(2, 8);
        check(o_key_event_bits, KEY_UP_BIT, "press bits");
        check(o_key_event_press, 1'b1, "press");
        i_keys = 6'h00;
        wait_on(2, 8);
        check(o_key_event_press, 1'b0, "release");
        i_cfg_press_mask = 8'h05;
        i_cfg_release_mask = 8'h0A;
        i_cfg_keys_wr = 1'b1;
        step(1);
        i_cfg_keys_wr = 1'b0;
        i_save_boot = 1'b1;
        step(1);
        i_save_boot = 1'b0;
        step(1);
        check(o_boot_press_mask, 8'h05, "saved press");
        check(o_boot_release_mask, 8'h0A, "saved release");
        $display("test reports done");
    endtask : t_reports

    task automatic t_poll();
        i_cfg_press_mask = 8'h00;
        i_cfg_release_mask = 8'h00;
        i_cfg_keys_wr = 1'b1;
        step(1);
        i_cfg_keys_wr = 1'b0;
        step(2);
        i_poll = 1'b1;
        step(1);
        i_poll = 1'b0;
        i_keys = 6'h10;
        for (int i = 0; i < 6; i++) begin
            step(1);
            check(o_key_event, 1'b0, "masked event");
        end
        for (int k = 0; k < 2; k++) begin
            i_poll = 1'b1;
            step(1);
            i_poll = 1'b0;
            i_keys = 6'h00;
            check(o_poll_valid, 1'b1, "poll valid");
            check(o_poll_held, k ? 8'h00 : KEY_EAST_BIT, "held");
            check(o_poll_pressed, k ? 8'h00 : KEY_EAST_BIT, "pr");
            check(o_poll_released, k ? KEY_EAST_BIT : 8'h00, "rl");
            step(6);
        end
        $display("test poll done");
    endtask : t_poll

    task automatic t_power_off();
        set_fn(FN_KEYPAD_PWR_OFF | FN_PWR_INVERT, 8'h02);
        i_keys = 6'h04;
        wait_on(0, 600);
        check(pwr_line, 1'b1, "inverted drive");
        check(o_pwr_out, 1'b1, "inverted level");
        check(o_message, 2'd3, "off message");
        step(40);
        check(o_pwr_oe, 1'b1, "extended drive");
        i_keys = 6'h00;
        step(8);
        check(o_pwr_oe, 1'b0, "released after key");
        $display("test power off done");
    endtask : t_power_off

    task automatic t_reset();
        set_fn(FN_KEYPAD_RESET, 8'h00);
        i_keys = 6'h02;
        wait_on(1, 600);
        check(rst_line, 1'b0, "reset drives low");
        check(o_message, 2'd1, "reset message");
        i_keys = 6'h00;
        i_cmd_valid = 1'b1;
        step(1);
        i_cmd_valid = 1'b0;
        check(o_cmd_accept, 1'b0, "cmd refused");
        wait_on(3, 200);
        check(o_rst_oe, 1'b0, "reset released");
        step(4);
        i_cmd_valid = 1'b1;
        step(1);
        i_cmd_valid = 1'b0;
        check(o_cmd_accept, 1'b1, "cmd accepted");
        $display("test reset done");
    endtask : t_reset

    task automatic t_power_on();
        host_on = 1'b0;
        set_fn(FN_KEYPAD_PWR_ON | FN_BLANK_WHEN_HOST_DOWN, 8'h00);
        step(4);
        check(o_display_blank, 1'b1, "blank while off");
        i_keys = 6'h02;
        wait_on(0, 100);
        i_keys = 6'h00;
        check(pwr_line, 1'b0, "power drives low");
        check(o_message, 2'd2, "on message");
        wait_on(3, 200);
        check(o_pwr_oe, 1'b0, "power released");
        // Host coming up while blanking is enabled must reboot the panel.
        host_on = 1'b1;
        wait_on(3, 8);
        check(o_display_blank, 1'b0, "unblank on sense");
        $display("test power on done");
    endtask : t_power_on

    initial begin
        step(3);
        i_rst_b = 1'b1;
        step(1);
        t_reports();
        t_poll();
        t_power_off();
        t_reset();
        t_power_on();
        give_verdict();
    end
endmodule : keypad_host_power_control_test
`default_nettype wire
